// ---- rtl/sac_conversion_control.sv ----
// Conversion control of the successive-approximation converter with its register slave.
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sac_conversion_control
  import sac_pkg::*;
#(
  parameter int POS_W = 7,
  parameter int NEG_W = 7
) (
  input  wire logic             CLK,
  input  wire logic             RESETN,
  input  wire logic [5:0]       AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  input  wire logic [3:0]       AVS_BYTEENABLE,
  output logic      [31:0]      AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  input  wire logic             EVENT_IN,
  input  wire logic             GLOBAL_IE,
  output logic                  IRQ,
  output logic                  DONE_EVENT,
  output logic                  SAR_ENABLE,
  output logic                  SAR_SAMPLE,
  output logic                  SAR_CONVERT,
  output logic                  SAR_DIFF,
  output logic      [POS_W-1:0] SAR_POS_SEL,
  output logic      [NEG_W-1:0] SAR_NEG_SEL,
  output logic                  ADC_CLK,
  input  wire logic [11:0]      SAR_DATA
);
  logic [7:0]       control_a;
  logic [7:0]       control_b;
  logic [7:0]       control_c;
  logic [7:0]       init_delay;
  logic [POS_W-1:0] pos_input_sel;
  logic [NEG_W-1:0] neg_input_sel;
  logic             event_start_en;
  logic [7:0]       int_ctrl;
  logic [1:0]       interrupt_flags;
  logic [15:0]      win_low;
  logic [15:0]      win_high;
  logic [15:0]      result;
  logic             ack;
  logic [31:0]      rdata;
  sac_state_e       state;
  sac_state_e       next_state;
  logic [8:0]       ph;
  logic [1:0]       fmt_cnt;
  logic [6:0]       smp;
  logic [18:0]      acc;
  logic             lat_diff;
  logic             lat_res10;
  logic             lat_left;
  logic             lat_trunc;
  logic [2:0]       lat_accum;
  logic [11:0]      sar_d1;
  logic [11:0]      sar_d2;
  logic             ev_prev;
  logic             enable_prev;
  logic             init_pending;
  logic             done_q;
  logic             irq_q;
  logic             half_tick;
  logic [15:0]      fmt_value;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be);
    logic [15:0] mask;
    mask = {{8{be[1]}}, {8{be[0]}}};
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic addr_is(input logic [5:0] addr,
                                   input logic [5:0] off);
    return addr == off;
  endfunction

  // Bus slave: one wait cycle, then the request is taken.
  wire req     = AVS_READ | AVS_WRITE;
  wire wr_fire = AVS_WRITE & ack;
  wire [1:0] be_lo = AVS_BYTEENABLE[1:0];
  wire [15:0] wd_lo = AVS_WRITEDATA[15:0];
  assign AVS_WAITREQUEST = req & ~ack;
  assign AVS_READDATA    = rdata;

  wire wr_ca = wr_fire & addr_is(AVS_ADDRESS, OFF_CONTROL_A);
  wire wr_cb = wr_fire & addr_is(AVS_ADDRESS, OFF_CONTROL_B);
  wire wr_cc = wr_fire & addr_is(AVS_ADDRESS, OFF_CONTROL_C);
  wire wr_cd = wr_fire & addr_is(AVS_ADDRESS, OFF_CONTROL_D);
  wire wr_ps = wr_fire & addr_is(AVS_ADDRESS, OFF_POS_SEL);
  wire wr_ns = wr_fire & addr_is(AVS_ADDRESS, OFF_NEG_SEL);
  wire wr_cm = wr_fire & addr_is(AVS_ADDRESS, OFF_COMMAND);
  wire wr_ev = wr_fire & addr_is(AVS_ADDRESS, OFF_EVENT_CTL);
  wire wr_ic = wr_fire & addr_is(AVS_ADDRESS, OFF_INT_CTRL);
  wire wr_fl = wr_fire & addr_is(AVS_ADDRESS, OFF_INT_FLAGS);
  wire wr_wl = wr_fire & addr_is(AVS_ADDRESS, OFF_WIN_LOW);
  wire wr_wh = wr_fire & addr_is(AVS_ADDRESS, OFF_WIN_HIGH);

  // Control fields.
  wire enable      = control_a[CA_ENABLE];
  wire cont_run    = control_a[CA_CONT];
  wire [2:0] wmode = int_ctrl[IC_WMODE +: 3];
  wire busy        = (state != ST_IDLE);

  // Triggers from software and from the event router.
  wire sw_start = wr_cm & be_lo[0] & AVS_WRITEDATA[0];
  wire ev_rise  = event_start_en & EVENT_IN & ~ev_prev;
  wire trigger  = enable & (sw_start | ev_rise);

  // Sequencing of the phases of one conversion.
  wire [8:0] init_half = {init_delay, 1'b0};
  wire [8:0] ph_target = (state == ST_INIT)   ? init_half :
                         (state == ST_SAMPLE) ? SAMPLE_HALF : CONVERT_HALF;
  wire ph_done   = half_tick & (ph == ph_target - 9'h001);
  wire fmt_end   = (state == ST_FORMAT) & (fmt_cnt == FORMAT_CYC - 2'h1);
  wire [7:0] n_samples = 8'h01 << lat_accum;
  wire last_sample = ({1'b0, smp} == n_samples - 8'h01);
  wire complete  = fmt_end & last_sample;
  wire need_init = init_pending & (init_delay != 8'h00);
  wire pre_run   = (state == ST_INIT) | (state == ST_SAMPLE) | (state == ST_CONVERT);

  // Sample extension and running sum.
  wire [18:0] sample_ext = lat_diff ? {{7{sar_d2[11]}}, sar_d2} : {7'h00, sar_d2};
  wire [18:0] acc_next   = acc + sample_ext;

  // Window comparison of the finished result.
  wire below_s = $signed(fmt_value) < $signed(win_low);
  wire above_s = $signed(fmt_value) > $signed(win_high);
  wire below_u = fmt_value < win_low;
  wire above_u = fmt_value > win_high;
  wire below   = lat_diff ? below_s : below_u;
  wire above   = lat_diff ? above_s : above_u;
  wire win_hit = (wmode == WM_BELOW)   ? below :
                 (wmode == WM_ABOVE)   ? above :
                 (wmode == WM_INSIDE)  ? (~below & ~above) :
                 (wmode == WM_OUTSIDE) ? (below | above) : 1'b0;

  // Flag set and clear terms.
  wire [1:0] flag_set = complete ? {win_hit, 1'b1} : 2'h0;
  wire [1:0] flag_clr = wr_fl ? (AVS_WRITEDATA[1:0] & {2{be_lo[0]}}) : 2'h0;
  wire [1:0] ie_bits  = {int_ctrl[IC_WIN], int_ctrl[IC_RR]};

  // Read selection.
  wire [31:0] rd_mux =
    addr_is(AVS_ADDRESS, OFF_CONTROL_A) ? {24'h0, control_a} :
    addr_is(AVS_ADDRESS, OFF_CONTROL_B) ? {24'h0, control_b} :
    addr_is(AVS_ADDRESS, OFF_CONTROL_C) ? {24'h0, control_c} :
    addr_is(AVS_ADDRESS, OFF_CONTROL_D) ? {24'h0, init_delay} :
    addr_is(AVS_ADDRESS, OFF_POS_SEL)   ? 32'(pos_input_sel) :
    addr_is(AVS_ADDRESS, OFF_NEG_SEL)   ? 32'(neg_input_sel) :
    addr_is(AVS_ADDRESS, OFF_COMMAND)   ? {31'h0, busy} :
    addr_is(AVS_ADDRESS, OFF_EVENT_CTL) ? {31'h0, event_start_en} :
    addr_is(AVS_ADDRESS, OFF_INT_CTRL)  ? {24'h0, int_ctrl} :
    addr_is(AVS_ADDRESS, OFF_INT_FLAGS) ? {30'h0, interrupt_flags} :
    addr_is(AVS_ADDRESS, OFF_RESULT)    ? {16'h0, result} :
    addr_is(AVS_ADDRESS, OFF_WIN_LOW)   ? {16'h0, win_low} :
    addr_is(AVS_ADDRESS, OFF_WIN_HIGH)  ? {16'h0, win_high} : 32'h0;

  // Enable, sample and convert outputs towards the analog core follow the live enable bit and the state.
  assign SAR_ENABLE  = enable;
  assign SAR_SAMPLE  = (state == ST_SAMPLE);
  assign SAR_CONVERT = (state == ST_CONVERT);
  assign IRQ         = irq_q;
  assign DONE_EVENT  = done_q;

  sac_prescaler #(
    .SEL_W (3)
  ) u_prescaler (
    .CLK       (CLK),
    .RESETN    (RESETN),
    .run       (pre_run),
    .div_sel   (control_c[2:0]),
    .half_tick (half_tick),
    .adc_clk   (ADC_CLK)
  );

  sac_result_format u_format (
    .acc       (acc_next),
    .accum_sel (lat_accum),
    .res10     (lat_res10),
    .diff      (lat_diff),
    .left      (lat_left),
    .trunc     (lat_trunc),
    .value     (fmt_value)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (trigger) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        next_state = need_init ? ST_INIT : ST_SAMPLE;
      end
      ST_INIT: begin
        if (ph_done) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (ph_done) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (ph_done) begin
          next_state = ST_FORMAT;
        end
      end
      ST_FORMAT: begin
        if (complete) begin
          next_state = cont_run ? ST_START : ST_IDLE;
        end else if (fmt_end) begin
          next_state = ST_SAMPLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!enable) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack   <= 1'b0;
      rdata <= 32'h0;
    end else begin
      ack   <= req & ~ack;
      rdata <= (req & ~ack) ? rd_mux : rdata;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      control_a      <= RST_CTRL;
      control_b      <= RST_CTRL;
      control_c      <= RST_CTRL;
      init_delay     <= RST_CTRL;
      pos_input_sel  <= '0;
      neg_input_sel  <= '0;
      event_start_en <= 1'b0;
      int_ctrl       <= RST_CTRL;
      win_low        <= RST_WIN_LOW;
      win_high       <= RST_WIN_HIGH;
    end else begin
      if (wr_ca) begin
        control_a <= 8'(merge16({8'h00, control_a}, wd_lo, be_lo));
      end
      if (wr_cb) begin
        control_b <= 8'(merge16({8'h00, control_b}, wd_lo, be_lo));
      end
      if (wr_cc) begin
        control_c <= 8'(merge16({8'h00, control_c}, wd_lo, be_lo));
      end
      if (wr_cd) begin
        init_delay <= 8'(merge16({8'h00, init_delay}, wd_lo, be_lo));
      end
      if (wr_ps) begin
        pos_input_sel <= POS_W'(merge16(16'(pos_input_sel), wd_lo, be_lo));
      end
      if (wr_ns) begin
        neg_input_sel <= NEG_W'(merge16(16'(neg_input_sel), wd_lo, be_lo));
      end
      if (wr_ev && be_lo[0]) begin
        event_start_en <= AVS_WRITEDATA[0];
      end
      if (wr_ic) begin
        int_ctrl <= 8'(merge16({8'h00, int_ctrl}, wd_lo, be_lo));
      end
      if (wr_wl) begin
        win_low <= merge16(win_low, wd_lo, be_lo);
      end
      if (wr_wh) begin
        win_high <= merge16(win_high, wd_lo, be_lo);
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state   <= ST_IDLE;
      ph      <= 9'h000;
      fmt_cnt <= 2'h0;
    end else begin
      state   <= next_state;
      ph      <= (state != next_state) ? 9'h000 : (half_tick ? ph + 9'h001 : ph);
      fmt_cnt <= (state == ST_FORMAT) ? fmt_cnt + 2'h1 : 2'h0;
    end
  end

  // Conversion settings and channels are taken at start only.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lat_diff    <= 1'b0;
      lat_res10   <= 1'b0;
      lat_left    <= 1'b0;
      lat_trunc   <= 1'b0;
      lat_accum   <= 3'h0;
      SAR_DIFF    <= 1'b0;
      SAR_POS_SEL <= '0;
      SAR_NEG_SEL <= '0;
    end else if (state == ST_START) begin
      lat_diff    <= control_a[CA_DIFF];
      lat_res10   <= control_a[CA_RES10];
      lat_left    <= control_a[CA_LEFT];
      lat_trunc   <= control_b[CB_TRUNC];
      lat_accum   <= control_b[2:0];
      SAR_DIFF    <= control_a[CA_DIFF];
      SAR_POS_SEL <= pos_input_sel;
      SAR_NEG_SEL <= neg_input_sel;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc <= 19'h0;
      smp <= 7'h00;
    end else if (state == ST_START) begin
      acc <= 19'h0;
      smp <= 7'h00;
    end else if (fmt_end) begin
      acc <= acc_next;
      smp <= smp + 7'h01;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sar_d1 <= 12'h000;
      sar_d2 <= 12'h000;
    end else begin
      sar_d1 <= SAR_DATA;
      sar_d2 <= sar_d1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ev_prev      <= 1'b0;
      enable_prev  <= 1'b0;
      init_pending <= 1'b0;
    end else begin
      ev_prev      <= EVENT_IN;
      enable_prev  <= enable;
      if (enable && !enable_prev) begin
        init_pending <= 1'b1;
      end else if ((state == ST_INIT && ph_done) || (state == ST_START && !need_init)) begin
        init_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      result          <= 16'h0000;
      interrupt_flags <= 2'h0;
      done_q          <= 1'b0;
      irq_q           <= 1'b0;
    end else begin
      result          <= complete ? fmt_value : result;
      interrupt_flags <= (interrupt_flags & ~flag_clr) | flag_set;
      done_q          <= complete;
      irq_q           <= GLOBAL_IE & |(interrupt_flags & ie_bits);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sac_pkg.sv ----
// Constants, register map and state type of the conversion control block.
package sac_pkg;
  localparam logic [5:0] OFF_CONTROL_A = 6'h00;
  localparam logic [5:0] OFF_CONTROL_B = 6'h04;
  localparam logic [5:0] OFF_CONTROL_C = 6'h08;
  localparam logic [5:0] OFF_CONTROL_D = 6'h0c;
  localparam logic [5:0] OFF_POS_SEL   = 6'h10;
  localparam logic [5:0] OFF_NEG_SEL   = 6'h14;
  localparam logic [5:0] OFF_COMMAND   = 6'h18;
  localparam logic [5:0] OFF_EVENT_CTL = 6'h1c;
  localparam logic [5:0] OFF_INT_CTRL  = 6'h20;
  localparam logic [5:0] OFF_INT_FLAGS = 6'h24;
  localparam logic [5:0] OFF_RESULT    = 6'h28;
  localparam logic [5:0] OFF_WIN_LOW   = 6'h2c;
  localparam logic [5:0] OFF_WIN_HIGH  = 6'h30;
  localparam int CA_ENABLE = 0;
  localparam int CA_DIFF   = 1;
  localparam int CA_CONT   = 2;
  localparam int CA_LEFT   = 3;
  localparam int CA_RES10  = 4;
  localparam int CB_TRUNC  = 4;
  localparam int IC_RR     = 0;
  localparam int IC_WIN    = 1;
  localparam int IC_WMODE  = 4;
  localparam int FL_RR     = 0;
  localparam int FL_WIN    = 1;
  localparam logic [7:0]  RST_CTRL     = 8'h00;
  localparam logic [15:0] RST_WIN_LOW  = 16'h0000;
  localparam logic [15:0] RST_WIN_HIGH = 16'hffff;
  localparam logic [8:0]  SAMPLE_HALF  = 9'h004;
  localparam logic [8:0]  CONVERT_HALF = 9'h01b;
  localparam logic [1:0]  FORMAT_CYC   = 2'h2;
  localparam logic [4:0]  SAMPLE_W     = 5'h0c;
  localparam logic [4:0]  RESULT_W     = 5'h10;
  localparam logic [2:0]  ACC_FIT_SEL  = 3'h4;
  localparam logic [2:0]  RES10_DROP   = 3'h2;
  localparam logic [2:0]  WM_BELOW     = 3'h1;
  localparam logic [2:0]  WM_ABOVE     = 3'h2;
  localparam logic [2:0]  WM_INSIDE    = 3'h3;
  localparam logic [2:0]  WM_OUTSIDE   = 3'h4;
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_START   = 6'h02,
    ST_INIT    = 6'h04,
    ST_SAMPLE  = 6'h08,
    ST_CONVERT = 6'h10,
    ST_FORMAT  = 6'h20
  } sac_state_e;
endpackage

// ---- rtl/sac_prescaler.sv ----
// Converter clock prescaler, held in reset while not running.
`timescale 1ns/1ps
`default_nettype none
module sac_prescaler #(
  parameter int SEL_W = 3
) (
  input  wire logic             CLK,
  input  wire logic             RESETN,
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] div_sel,
  output logic                  half_tick,
  output logic                  adc_clk
);
  localparam int CNT_W = 1 << SEL_W;
  logic [CNT_W-1:0] cnt;
  wire  [CNT_W-1:0] half_len = CNT_W'(1) << div_sel;
  wire              wrap     = (cnt == half_len - CNT_W'(1));
  assign half_tick = run & wrap;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt     <= '0;
      adc_clk <= 1'b0;
    end else if (!run) begin
      cnt     <= '0;
      adc_clk <= 1'b0;
    end else if (wrap) begin
      cnt     <= '0;
      adc_clk <= ~adc_clk;
    end else begin
      cnt     <= cnt + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sac_result_format.sv ----
// Shapes the accumulated sum into the 16-bit result value.
`timescale 1ns/1ps
`default_nettype none
module sac_result_format
  import sac_pkg::*;
(
  input  wire logic [18:0] acc,
  input  wire logic [2:0]  accum_sel,
  input  wire logic        res10,
  input  wire logic        diff,
  input  wire logic        left,
  input  wire logic        trunc,
  output logic      [15:0] value
);
  wire [2:0]  over    = (accum_sel > ACC_FIT_SEL) ? accum_sel - ACC_FIT_SEL : 3'h0;
  wire [2:0]  drop    = (accum_sel == 3'h0 && res10) ? RES10_DROP : 3'h0;
  wire [2:0]  rsh     = trunc ? accum_sel : over;
  wire [2:0]  total   = rsh + drop;
  wire [18:0] sshift  = 19'($signed(acc) >>> total);
  wire [18:0] ushift  = acc >> total;
  wire [18:0] shifted = diff ? sshift : ushift;
  wire [4:0]  width   = SAMPLE_W + {2'h0, accum_sel} - {2'h0, total};
  wire [4:0]  lsh     = RESULT_W - width;
  assign value = left ? (shifted[15:0] << lsh) : shifted[15:0];
endmodule
`default_nettype wire

// ---- tb/sac_sar_model.sv ----
// Behavioural model of the analog converter core that delivers each sample.
`timescale 1ns/1ps
`default_nettype none
module sac_sar_model (
  input  wire logic        CLK,
  input  wire logic        SAR_ENABLE,
  input  wire logic        SAR_SAMPLE,
  input  wire logic        SAR_DIFF,
  input  wire logic [6:0]  SAR_POS_SEL,
  output logic      [11:0] SAR_DATA = 12'h5a5
);
  // The sample is taken while sampling and held through conversion and formatting.
  always_ff @(posedge CLK) begin
    if (SAR_SAMPLE) begin
      SAR_DATA <= SAR_DIFF ? {5'h10, SAR_POS_SEL} : {5'h05, SAR_POS_SEL};
    end else if (!SAR_ENABLE) begin
      SAR_DATA <= ~SAR_DATA;
    end
  end
endmodule
`default_nettype wire

// ---- tb/sac_conversion_props.sv ----
// Concurrent checks on the ports of the conversion control block.
`timescale 1ns/1ps
`default_nettype none
module sac_conversion_props
  import sac_pkg::*;
#(
  parameter int POS_W = 7
) (
  input  wire logic             CLK,
  input  wire logic             RESETN,
  input  wire logic [5:0]       AVS_ADDRESS,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  input  wire logic             AVS_WAITREQUEST,
  input  wire logic             GLOBAL_IE,
  input  wire logic             IRQ,
  input  wire logic             DONE_EVENT,
  input  wire logic             SAR_ENABLE,
  input  wire logic             SAR_SAMPLE,
  input  wire logic             SAR_CONVERT,
  input  wire logic             SAR_DIFF,
  input  wire logic [POS_W-1:0] SAR_POS_SEL,
  input  wire logic             ADC_CLK
);
  logic [5:0] conv_cnt;
  wire        start_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFF_COMMAND && AVS_WRITEDATA[0];
  // Counts the cycles of the current convert phase.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      conv_cnt <= 6'h00;
    end else begin
      conv_cnt <= SAR_CONVERT ? conv_cnt + 6'h01 : 6'h00;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  clk_held_idle_a: assert property (!SAR_ENABLE [*4] |-> !ADC_CLK)
    else $error("Converter clock runs while disabled.");
  sample_length_a: assert property ($rose(SAR_SAMPLE) |-> SAR_SAMPLE [*4])
    else $error("Sample phase too short.");
  convert_length_a: assert property ($fell(SAR_CONVERT) && SAR_ENABLE |-> conv_cnt >= 6'h1b)
    else $error("Convert phase too short.");
  done_timing_a: assert property (DONE_EVENT |-> $past(SAR_CONVERT, 3) && !$past(SAR_CONVERT, 2) && !$past(SAR_CONVERT, 1))
    else $error("Completion not two format cycles after convert.");
  done_pulse_a: assert property (DONE_EVENT |=> !DONE_EVENT)
    else $error("Completion event longer than one cycle.");
  irq_gate_a: assert property (!GLOBAL_IE |=> !IRQ)
    else $error("Interrupt raised without global enable.");
  start_delay_a: assert property (start_wr && SAR_ENABLE && !SAR_SAMPLE && !SAR_CONVERT |=> !SAR_SAMPLE ##1 SAR_SAMPLE)
    else $error("Sampling did not begin two cycles after start.");
  channel_hold_a: assert property (SAR_CONVERT |-> $stable(SAR_POS_SEL) && $stable(SAR_DIFF))
    else $error("Channel or mode changed during conversion.");
endmodule
bind sac_conversion_control sac_conversion_props #(.POS_W(POS_W)) sac_conversion_props_inst (
  .CLK, .RESETN, .AVS_ADDRESS, .AVS_WRITE, .AVS_WRITEDATA, .AVS_WAITREQUEST, .GLOBAL_IE, .IRQ,
  .DONE_EVENT, .SAR_ENABLE, .SAR_SAMPLE, .SAR_CONVERT, .SAR_DIFF, .SAR_POS_SEL, .ADC_CLK);
`default_nettype wire

// ---- tb/sac_conversion_control_bench.sv ----
// Self-checking bench for the conversion control block.
`timescale 1ns/1ps
`default_nettype none
module sac_conversion_control_bench
  import sac_pkg::*;
;
  logic        CLK, RESETN, AVS_READ, AVS_WRITE, EVENT_IN, GLOBAL_IE;
  logic [5:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [3:0]  AVS_BYTEENABLE;
  logic        AVS_WAITREQUEST, IRQ, DONE_EVENT, SAR_ENABLE, SAR_SAMPLE, SAR_CONVERT, SAR_DIFF, ADC_CLK;
  logic [6:0]  SAR_POS_SEL, SAR_NEG_SEL;
  logic [11:0] SAR_DATA;
  logic [7:0]  done_seen, done_base;
  int          bad_count, comparisons, i;
  logic [31:0] mode_cfg [3] = '{32'h03, 32'h09, 32'h11};
  logic [31:0] mode_res [3] = '{32'hf822, 32'h2a20, 32'h00a8};
  logic [31:0] win_flag [4] = '{32'h1, 32'h1, 32'h3, 32'h1};
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("FAIL at %0t: got %h expected %h", $time, got, exp); \
  end \
end
  sac_conversion_control sac_conversion_control_inst (.CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .EVENT_IN(EVENT_IN), .GLOBAL_IE(GLOBAL_IE),
    .IRQ(IRQ), .DONE_EVENT(DONE_EVENT), .SAR_ENABLE(SAR_ENABLE), .SAR_SAMPLE(SAR_SAMPLE), .SAR_CONVERT(SAR_CONVERT),
    .SAR_DIFF(SAR_DIFF), .SAR_POS_SEL(SAR_POS_SEL), .SAR_NEG_SEL(SAR_NEG_SEL), .ADC_CLK(ADC_CLK), .SAR_DATA(SAR_DATA));
  sac_sar_model sac_sar_model_inst (.CLK(CLK), .SAR_ENABLE(SAR_ENABLE), .SAR_SAMPLE(SAR_SAMPLE),
    .SAR_DIFF(SAR_DIFF), .SAR_POS_SEL(SAR_POS_SEL), .SAR_DATA(SAR_DATA));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (!RESETN) begin
      done_seen <= 8'h00;
    end else if (DONE_EVENT === 1'b1) begin
      done_seen <= done_seen + 8'h01;
    end
  end
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One bus access: held until waitrequest is seen low, then released for a cycle.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    rd = AVS_READDATA;
    `CHK(AVS_WAITREQUEST, 1'b0)
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic fin(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_COMMAND, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    chk(OFF_RESULT, e);
  endtask
  task automatic conv(input logic [31:0] e);
    wr(OFF_COMMAND, 32'h1);
    chk(OFF_COMMAND, 32'h1);
    fin(e);
  endtask
  initial begin
    #200000;
    bad_count++;
    close_out;
  end
  initial begin
    RESETN = 1'b0;
    {AVS_READ, AVS_WRITE, EVENT_IN, GLOBAL_IE} = 4'h0;
    AVS_ADDRESS = 6'h00;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'hf;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    chk(OFF_CONTROL_A, 32'h0);
    chk(OFF_WIN_HIGH, 32'hffff);
    chk(OFF_INT_FLAGS, 32'h0);
    wr(6'h3c, 32'hffff);
    chk(6'h3c, 32'h0);
    wr(OFF_POS_SEL, 32'h11);
    wr(OFF_CONTROL_A, 32'h1);
    conv(32'h0291);
    chk(OFF_INT_FLAGS, 32'h1);
    `CHK(IRQ, 1'b0)
    wr(OFF_INT_FLAGS, 32'h1);
    chk(OFF_INT_FLAGS, 32'h0);
    wr(OFF_COMMAND, 32'h1);
    wr(OFF_POS_SEL, 32'h22);
    fin(32'h0291);
    conv(32'h02a2);
    wr(OFF_NEG_SEL, 32'h05);
    for (i = 0; i < 3; i++) begin
      wr(OFF_CONTROL_A, mode_cfg[i]);
      conv(mode_res[i]);
    end
    `CHK(SAR_NEG_SEL, 7'h05)
    wr(OFF_CONTROL_A, 32'h1);
    wr(OFF_CONTROL_B, 32'h2);
    conv(32'h0a88);
    conv(32'h0a88);
    wr(OFF_CONTROL_B, 32'h7);
    conv(32'h2a20);
    wr(OFF_CONTROL_B, 32'h12);
    conv(32'h02a2);
    wr(OFF_CONTROL_B, 32'h0);
    wr(OFF_CONTROL_C, 32'h1);
    conv(32'h02a2);
    wr(OFF_CONTROL_C, 32'h0);
    wr(OFF_INT_FLAGS, 32'h3);
    wr(OFF_INT_CTRL, 32'h1);
    GLOBAL_IE <= 1'b1;
    conv(32'h02a2);
    `CHK(IRQ, 1'b1)
    GLOBAL_IE <= 1'b0;
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'b0)
    wr(OFF_WIN_LOW, 32'h200);
    wr(OFF_WIN_HIGH, 32'h300);
    for (i = 0; i < 4; i++) begin
      wr(OFF_INT_FLAGS, 32'h3);
      wr(OFF_INT_CTRL, (i + 1) << 4);
      conv(32'h02a2);
      chk(OFF_INT_FLAGS, win_flag[i]);
    end
    wr(OFF_INT_CTRL, 32'h0);
    GLOBAL_IE <= 1'b1;
    wr(OFF_EVENT_CTL, 32'h1);
    EVENT_IN <= 1'b1;
    @(posedge CLK);
    EVENT_IN <= 1'b0;
    chk(OFF_COMMAND, 32'h1);
    fin(32'h02a2);
    `CHK(IRQ, 1'b0)
    wr(OFF_EVENT_CTL, 32'h0);
    wr(OFF_CONTROL_A, 32'h5);
    done_base = done_seen;
    wr(OFF_COMMAND, 32'h1);
    repeat (80) @(posedge CLK);
    `CHK(done_seen - done_base, 8'h02)
    chk(OFF_COMMAND, 32'h1);
    wr(OFF_CONTROL_A, 32'h1);
    fin(32'h02a2);
    wr(OFF_CONTROL_A, 32'h0);
    wr(OFF_CONTROL_D, 32'h3);
    wr(OFF_POS_SEL, 32'h11);
    wr(OFF_EVENT_CTL, 32'h1);
    wr(OFF_CONTROL_A, 32'h1);
    EVENT_IN <= 1'b1;
    @(posedge CLK);
    EVENT_IN <= 1'b0;
    repeat (4) @(posedge CLK);
    `CHK(SAR_SAMPLE, 1'b0)
    chk(OFF_COMMAND, 32'h1);
    fin(32'h0291);
    close_out;
  end
endmodule
`default_nettype wire
